// ==== ifnm_consts.vh ====
// Operation
// - First stage is a symmetric 59-tap half-band, center 65536, largest side 41527.
// - Later stages: 23, 11, 11-tap half-bands and 9-tap inverse-sinc, fixed taps.
// - Inverse-sinc runs once, at full output rate, after the last interpolation stage and the mixer.
// - Two complex mixer paths, each serving one pair of channels.
// - Each mixer has its own independently programmed oscillator.
// - Each oscillator holds a software-written 32-bit frequency word.
// - Each oscillator holds a 16-bit phase offset word used for sine/cosine.
// - A synchronization event clears the phase accumulators to zero.
// - A 4-bit select field in a configuration register picks the sync event.
// - Every clock cycle the frequency word is added into its accumulator.
// - Output frequency equals frequency word times clock rate over 2^32.
// - Mixer output: I*cos - Q*sin and I*sin + Q*cos per channel pair.
// - Mixing phase counts from the most recent accumulator clear.
// - Phase offset equals two pi times phase word over 2^16.
// - Multiplier outputs scaled by 2^(gain-1): gain 0 halves, gain 1 unscaled.
// - Gain bit lives in the general configuration register.
`ifndef IFNM_CONSTS_VH
`define IFNM_CONSTS_VH

// Register byte offsets
`define IFNM_OFS_FREQ0 8'h00
`define IFNM_OFS_FREQ1 8'h04
`define IFNM_OFS_PHASE0 8'h08
`define IFNM_OFS_PHASE1 8'h0c
`define IFNM_OFS_SYNC_CFG 8'h10
`define IFNM_OFS_GEN_CFG 8'h14
`define IFNM_OFS_SYNC_TRIG 8'h18
`define IFNM_OFS_ACC0 8'h1c
`define IFNM_OFS_ACC1 8'h20

// Sync select field bits
`define IFNM_SYNC_SEL_SW 0
`define IFNM_SYNC_SEL_PIN 1
`define IFNM_SYNC_SEL_OSTR 2
`define IFNM_SYNC_SEL_HOLD 3

// General config field bits
`define IFNM_GCFG_GAIN 0
`define IFNM_GCFG_MIXEN 1

// Reset values
`define IFNM_FREQ_RST 32'h0000_0000
`define IFNM_PHASE_RST 16'h0000
`define IFNM_SYNC_SEL_RST 4'h0
`define IFNM_GAIN_RST 1'b1
`define IFNM_MIXEN_RST 1'b0

// Half tap sets, outermost tap first, center tap last, 18-bit signed
`define IFNM_HB1_COEF {18'h00006, 18'h00000, 18'h3ffed, 18'h00000, \
	18'h0002f, 18'h00000, 18'h3ff9c, 18'h00000, 18'h000c0, 18'h00000, \
	18'h3feaa, 18'h00000, 18'h0023c, 18'h00000, 18'h3fc6e, 18'h00000, \
	18'h00581, 18'h00000, 18'h3f7b9, 18'h00000, 18'h00c50, 18'h00000, \
	18'h3ed87, 18'h00000, 18'h01cfc, 18'h00000, 18'h3cbea, 18'h00000, \
	18'h0a237, 18'h10000}
`define IFNM_HB2_COEF {18'h3fff4, 18'h00000, 18'h00054, 18'h00000, \
	18'h3feb0, 18'h00000, 18'h003ee, 18'h00000, 18'h3f57d, 18'h00000, \
	18'h0279d, 18'h04000}
`define IFNM_HB3_COEF {18'h0001d, 18'h00000, 18'h3ff2a, 18'h00000, \
	18'h004b9, 18'h00800}
`define IFNM_HB4_COEF {18'h00003, 18'h00000, 18'h3ffe7, 18'h00000, \
	18'h00096, 18'h00100}
`define IFNM_ISINC_COEF {18'h00001, 18'h3fffc, 18'h0000d, 18'h3ffce, \
	18'h00250}

// Tap counts and normalising shifts (each phase sums to 2^shift)
`define IFNM_HB1_TAPS 59
`define IFNM_HB2_TAPS 23
`define IFNM_HB3_TAPS 11
`define IFNM_HB4_TAPS 11
`define IFNM_ISINC_TAPS 9
`define IFNM_HB1_SHIFT 16
`define IFNM_HB2_SHIFT 14
`define IFNM_HB3_SHIFT 11
`define IFNM_HB4_SHIFT 8
`define IFNM_ISINC_SHIFT 9
`define IFNM_HB_INTERP 2
`define IFNM_ISINC_INTERP 1

// Mixer fraction bits of the sine table
`define IFNM_TRIG_FRAC 15

`endif

// ==== ifnm_fir.v ====
`timescale 1ns/1ps
`include "ifnm_consts.vh"

module ifnm_fir #(
	parameter NTAP = 9,
	parameter INTERP = 1,
	parameter SHIFT = 9,
	parameter NCH = 4,
	parameter W = 16,
	parameter CW = 18,
	parameter [CW*((NTAP+1)/2)-1:0] COEF = {(CW*((NTAP+1)/2)){1'b0}}
) (
	// Clock and reset
	input wire clk_sys,
	input wire rst_b,
	// Input stream, all lanes in step
	input wire [NCH*W-1:0] in_data,
	input wire in_valid,
	output wire in_ready,
	// Output stream
	output wire [NCH*W-1:0] out_data,
	output wire out_valid,
	input wire out_ready
);
	localparam HALF = (NTAP + 1) / 2;
	localparam L = (NTAP - 1) / INTERP + 1;
	localparam AW = W + CW + 6;

	reg [W-1:0] hist_reg [0:NCH*L-1];
	reg idle_reg;
	reg [1:0] phase_reg;
	reg out_valid_reg;
	reg [NCH*W-1:0] out_reg;
	wire [NCH*W-1:0] sat_w;

	// One input yields INTERP outputs; new input waits until all are out
	wire take = in_valid && idle_reg;
	wire emit = !idle_reg && (!out_valid_reg || out_ready);
	wire last = (phase_reg == INTERP - 1);

	assign in_ready = idle_reg;
	assign out_data = out_reg;
	assign out_valid = out_valid_reg;

	genvar c;
	generate
		for (c = 0; c < NCH; c = c + 1) begin : lane
			reg signed [AW-1:0] acc;
			reg signed [AW-1:0] sh;
			reg [W-1:0] sat;
			// Polyphase sum: only taps of the current phase meet real samples
			always @* begin : mac
				integer k;
				integer j;
				acc = {AW{1'b0}};
				k = 0;
				j = 0;
				for (k = 0; k < NTAP; k = k + 1) begin
					j = (k < HALF) ? k : NTAP - 1 - k;
					if ((k % INTERP) == phase_reg)
						acc = acc + $signed(hist_reg[c*L + (k - phase_reg) / INTERP])
							* $signed(COEF[(HALF-1-j)*CW +: CW]);
				end
				sh = acc >>> SHIFT;
				// Clip instead of wrapping on overshoot
				if (&sh[AW-1:W-1] || ~|sh[AW-1:W-1])
					sat = sh[W-1:0];
				else
					sat = sh[AW-1] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}};
			end
			assign sat_w[c*W +: W] = sat;
		end
	endgenerate

	// History shift and output handshake
	always @(posedge clk_sys or negedge rst_b) begin : seq
		integer i;
		integer m;
		if (!rst_b) begin
			for (i = 0; i < NCH*L; i = i + 1)
				hist_reg[i] <= {W{1'b0}};
			idle_reg <= 1'b1;
			phase_reg <= 2'h0;
			out_valid_reg <= 1'b0;
			out_reg <= {(NCH*W){1'b0}};
		end else begin
			if (take) begin
				// Per lane: newest word at the head, older ones shift down
				for (i = 0; i < NCH; i = i + 1) begin
					hist_reg[i*L] <= in_data[i*W +: W];
					for (m = 1; m < L; m = m + 1)
						hist_reg[i*L+m] <= hist_reg[i*L+m-1];
				end
				idle_reg <= 1'b0;
				phase_reg <= 2'h0;
			end
			if (emit) begin
				out_reg <= sat_w;
				out_valid_reg <= 1'b1;
				if (last)
					idle_reg <= 1'b1;
				else
					phase_reg <= phase_reg + 2'h1;
			end else if (out_ready) begin
				out_valid_reg <= 1'b0;
			end
		end
	end
endmodule // ifnm_fir

// ==== ifnm_mixer_top.v ====
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "ifnm_consts.vh"

module ifnm_mixer_top (
	// Clock and reset
	input wire clk_sys,
	input wire rst_b,
	// Register port
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output wire [31:0] reg_rdata,
	// Sync pins
	input wire sync_pin,
	input wire ostr_pin,
	// Sample input, lanes A B C D low to high
	input wire [63:0] smp_in_data,
	input wire smp_in_valid,
	output wire smp_in_ready,
	// Sample output
	output wire [63:0] smp_out_data,
	output wire smp_out_valid,
	input wire smp_out_ready
);
	reg [31:0] freq_reg [0:1];
	reg [15:0] phase_reg [0:1];
	reg [31:0] acc_reg [0:1];
	reg [3:0] sync_sel_reg;
	reg gain_reg;
	reg mix_en_reg;
	reg [31:0] rdata_reg;
	reg [31:0] rd_mux;
	reg [2:0] sync_sh_reg;
	reg [2:0] ostr_sh_reg;
	reg [63:0] mix_data_reg;
	reg mix_valid_reg;
	reg [63:0] head_reg;
	reg [63:0] tail_reg;
	reg [1:0] cnt_reg;
	reg [1:0] cnt_next;
	reg out_valid_reg;
	reg full_reg;

	wire [63:0] d0, d1, d2, d3, d4;
	wire v0, v1, v2, v3, v4;
	wire r1, r2, r3, r4;
	wire [63:0] mix_out_w;
	wire mix_ready;
	wire push;
	wire pop;

	assign reg_rdata = rdata_reg;
	assign smp_out_data = head_reg;
	assign smp_out_valid = out_valid_reg;

	// Quarter-wave sine, 64 steps per turn; spurs near -36 dBc
	function [15:0] ifnm_sin;
		input [5:0] p;
		reg [4:0] idx;
		reg [15:0] mag;
		begin
			idx = p[4] ? 5'h10 - {1'b0, p[3:0]} : {1'b0, p[3:0]};
			case (idx)
				5'h00: mag = 16'h0000;
				5'h01: mag = 16'h0c8c;
				5'h02: mag = 16'h18f9;
				5'h03: mag = 16'h2528;
				5'h04: mag = 16'h30fb;
				5'h05: mag = 16'h3c56;
				5'h06: mag = 16'h471c;
				5'h07: mag = 16'h5133;
				5'h08: mag = 16'h5a82;
				5'h09: mag = 16'h62f1;
				5'h0a: mag = 16'h6a6d;
				5'h0b: mag = 16'h70e2;
				5'h0c: mag = 16'h7641;
				5'h0d: mag = 16'h7a7c;
				5'h0e: mag = 16'h7d89;
				5'h0f: mag = 16'h7f61;
				5'h10: mag = 16'h7fff;
				default: mag = 16'h0000;
			endcase
			ifnm_sin = p[5] ? 16'h0000 - mag : mag;
		end
	endfunction

	// Clip a 33-bit product sum to 16 bits
	function [15:0] ifnm_sat;
		input [32:0] v;
		begin
			if (&v[32:15] || ~|v[32:15])
				ifnm_sat = v[15:0];
			else
				ifnm_sat = v[32] ? 16'h8000 : 16'h7fff;
		end
	endfunction

	// Register writes
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			freq_reg[0] <= `IFNM_FREQ_RST;
			freq_reg[1] <= `IFNM_FREQ_RST;
			phase_reg[0] <= `IFNM_PHASE_RST;
			phase_reg[1] <= `IFNM_PHASE_RST;
			sync_sel_reg <= `IFNM_SYNC_SEL_RST;
			gain_reg <= `IFNM_GAIN_RST;
			mix_en_reg <= `IFNM_MIXEN_RST;
		end else if (reg_wr) begin
			case (reg_addr)
				`IFNM_OFS_FREQ0: freq_reg[0] <= reg_wdata;
				`IFNM_OFS_FREQ1: freq_reg[1] <= reg_wdata;
				`IFNM_OFS_PHASE0: phase_reg[0] <= reg_wdata[15:0];
				`IFNM_OFS_PHASE1: phase_reg[1] <= reg_wdata[15:0];
				`IFNM_OFS_SYNC_CFG: sync_sel_reg <= reg_wdata[3:0];
				`IFNM_OFS_GEN_CFG: begin
					gain_reg <= reg_wdata[`IFNM_GCFG_GAIN];
					mix_en_reg <= reg_wdata[`IFNM_GCFG_MIXEN];
				end
				default: ;
			endcase
		end
	end

	// Read mux; trigger offset and unmapped addresses read zero
	always @* begin
		case (reg_addr)
			`IFNM_OFS_FREQ0: rd_mux = freq_reg[0];
			`IFNM_OFS_FREQ1: rd_mux = freq_reg[1];
			`IFNM_OFS_PHASE0: rd_mux = {16'h0000, phase_reg[0]};
			`IFNM_OFS_PHASE1: rd_mux = {16'h0000, phase_reg[1]};
			`IFNM_OFS_SYNC_CFG: rd_mux = {28'h0000000, sync_sel_reg};
			`IFNM_OFS_GEN_CFG: rd_mux = {30'h0, mix_en_reg, gain_reg};
			`IFNM_OFS_ACC0: rd_mux = acc_reg[0];
			`IFNM_OFS_ACC1: rd_mux = acc_reg[1];
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Read data valid only in the cycle after the strobe
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b)
			rdata_reg <= 32'h0000_0000;
		else
			rdata_reg <= reg_rd ? rd_mux : 32'h0000_0000;
	end

	// Pin synchronisers; third stage only for edge detect
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			sync_sh_reg <= 3'h0;
			ostr_sh_reg <= 3'h0;
		end else begin
			sync_sh_reg <= {sync_sh_reg[1:0], sync_pin};
			ostr_sh_reg <= {ostr_sh_reg[1:0], ostr_pin};
		end
	end

	wire sync_rise = sync_sh_reg[1] & ~sync_sh_reg[2];
	wire ostr_rise = ostr_sh_reg[1] & ~ostr_sh_reg[2];
	wire sw_sync = reg_wr && (reg_addr == `IFNM_OFS_SYNC_TRIG);
	wire osc_clear = (sync_sel_reg[`IFNM_SYNC_SEL_SW] & sw_sync)
		| (sync_sel_reg[`IFNM_SYNC_SEL_PIN] & sync_rise)
		| (sync_sel_reg[`IFNM_SYNC_SEL_OSTR] & ostr_rise)
		| sync_sel_reg[`IFNM_SYNC_SEL_HOLD];

	// two mixer paths, one per pair
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : pair
			wire [15:0] ph_w;
			wire signed [15:0] sin_w;
			wire signed [15:0] cos_w;
			wire signed [15:0] i_w;
			wire signed [15:0] q_w;
			wire signed [31:0] ic_w, qs_w, is_w, qc_w;
			wire signed [32:0] ri_w, rq_w;
			wire [32:0] si_w, sq_w;

			always @(posedge clk_sys or negedge rst_b) begin
				if (!rst_b)
					acc_reg[g] <= 32'h0000_0000;
				else if (osc_clear)
					acc_reg[g] <= 32'h0000_0000;
				// add every cycle, wraps mod 2^32
				else
					acc_reg[g] <= acc_reg[g] + freq_reg[g];
			end

			// offset aligned to top 16 bits
			assign ph_w = acc_reg[g][31:16] + phase_reg[g];
			assign sin_w = ifnm_sin(ph_w[15:10]);
			assign cos_w = ifnm_sin(ph_w[15:10] + 6'h10);

			assign i_w = d3[32*g +: 16];
			assign q_w = d3[32*g+16 +: 16];
			assign ic_w = i_w * cos_w;
			assign qs_w = q_w * sin_w;
			assign is_w = i_w * sin_w;
			assign qc_w = q_w * cos_w;
			assign ri_w = {ic_w[31], ic_w} - {qs_w[31], qs_w};
			assign rq_w = {is_w[31], is_w} + {qc_w[31], qc_w};
			assign si_w = gain_reg ? ri_w >>> `IFNM_TRIG_FRAC
				: ri_w >>> (`IFNM_TRIG_FRAC + 1);
			assign sq_w = gain_reg ? rq_w >>> `IFNM_TRIG_FRAC
				: rq_w >>> (`IFNM_TRIG_FRAC + 1);
			assign mix_out_w[32*g +: 32] = mix_en_reg
				? {ifnm_sat(sq_w), ifnm_sat(si_w)} : d3[32*g +: 32];
		end
	endgenerate

	ifnm_fir #(
		.NTAP(`IFNM_HB1_TAPS), .INTERP(`IFNM_HB_INTERP),
		.SHIFT(`IFNM_HB1_SHIFT), .COEF(`IFNM_HB1_COEF)
	) first_halfband_stage (
		.clk_sys(clk_sys), .rst_b(rst_b),
		.in_data(smp_in_data), .in_valid(smp_in_valid),
		.in_ready(smp_in_ready),
		.out_data(d0), .out_valid(v0), .out_ready(r1)
	);

	ifnm_fir #(
		.NTAP(`IFNM_HB2_TAPS), .INTERP(`IFNM_HB_INTERP),
		.SHIFT(`IFNM_HB2_SHIFT), .COEF(`IFNM_HB2_COEF)
	) second_halfband_stage (
		.clk_sys(clk_sys), .rst_b(rst_b),
		.in_data(d0), .in_valid(v0), .in_ready(r1),
		.out_data(d1), .out_valid(v1), .out_ready(r2)
	);

	ifnm_fir #(
		.NTAP(`IFNM_HB3_TAPS), .INTERP(`IFNM_HB_INTERP),
		.SHIFT(`IFNM_HB3_SHIFT), .COEF(`IFNM_HB3_COEF)
	) third_halfband_stage (
		.clk_sys(clk_sys), .rst_b(rst_b),
		.in_data(d1), .in_valid(v1), .in_ready(r2),
		.out_data(d2), .out_valid(v2), .out_ready(r3)
	);

	ifnm_fir #(
		.NTAP(`IFNM_HB4_TAPS), .INTERP(`IFNM_HB_INTERP),
		.SHIFT(`IFNM_HB4_SHIFT), .COEF(`IFNM_HB4_COEF)
	) fourth_halfband_stage (
		.clk_sys(clk_sys), .rst_b(rst_b),
		.in_data(d2), .in_valid(v2), .in_ready(r3),
		.out_data(d3), .out_valid(v3), .out_ready(mix_ready)
	);

	// Mixer pipeline register; samples use the phase of their entry cycle
	assign mix_ready = !mix_valid_reg || r4;
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			mix_data_reg <= 64'h0;
			mix_valid_reg <= 1'b0;
		end else if (v3 && mix_ready) begin
			mix_data_reg <= mix_out_w;
			mix_valid_reg <= 1'b1;
		end else if (r4) begin
			mix_valid_reg <= 1'b0;
		end
	end

	ifnm_fir #(
		.NTAP(`IFNM_ISINC_TAPS), .INTERP(`IFNM_ISINC_INTERP),
		.SHIFT(`IFNM_ISINC_SHIFT), .COEF(`IFNM_ISINC_COEF)
	) inverse_sinc_stage (
		.clk_sys(clk_sys), .rst_b(rst_b),
		.in_data(mix_data_reg), .in_valid(mix_valid_reg), .in_ready(r4),
		.out_data(d4), .out_valid(v4), .out_ready(!full_reg)
	);

	// Two-entry output buffer so a receiver stall drops nothing
	assign push = v4 && !full_reg;
	assign pop = out_valid_reg && smp_out_ready;
	always @* begin
		cnt_next = cnt_reg;
		if (push && !pop)
			cnt_next = cnt_reg + 2'h1;
		else if (pop && !push)
			cnt_next = cnt_reg - 2'h1;
	end

	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			head_reg <= 64'h0;
			tail_reg <= 64'h0;
			cnt_reg <= 2'h0;
			out_valid_reg <= 1'b0;
			full_reg <= 1'b0;
		end else begin
			if (pop) begin
				if (cnt_reg == 2'h2) begin
					head_reg <= tail_reg;
					if (push)
						tail_reg <= d4;
				end else if (push) begin
					head_reg <= d4;
				end
			end else if (push) begin
				if (cnt_reg == 2'h0)
					head_reg <= d4;
				else
					tail_reg <= d4;
			end
			cnt_reg <= cnt_next;
			out_valid_reg <= (cnt_next != 2'h0);
			full_reg <= (cnt_next == 2'h2);
		end
	end
endmodule // ifnm_mixer_top

// ==== ifnm_partner.sv ====
`timescale 1ns/1ps
module ifnm_partner (
	// Clock and reset
	input wire clk_sys,
	input wire rst_b,
	// Source control
	input wire [63:0] src_word,
	input wire [31:0] src_limit,
	// Toward the block
	output wire [63:0] smp_in_data,
	output wire smp_in_valid,
	input wire smp_in_ready,
	// From the block
	input wire [63:0] smp_out_data,
	input wire smp_out_valid,
	output wire smp_out_ready,
	// Counts seen
	output reg [31:0] sent_cnt,
	output reg [31:0] recv_cnt,
	output reg [63:0] last_out
);
	reg [1:0] stall_reg;
	// Idle data inverted so a stale word never looks valid
	assign smp_in_valid = sent_cnt < src_limit;
	assign smp_in_data = smp_in_valid ? src_word : ~src_word;
	// Sink refuses one cycle in three to load the buffers
	assign smp_out_ready = stall_reg != 2'h0;
	// Count words both ways, keep the latest result
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			stall_reg <= 2'h0;
			sent_cnt <= 32'h0;
			recv_cnt <= 32'h0;
			last_out <= 64'h0;
		end else begin
			stall_reg <= (stall_reg == 2'h2) ? 2'h0 : stall_reg + 2'h1;
			if (smp_in_valid && smp_in_ready)
				sent_cnt <= sent_cnt + 32'h1;
			if (smp_out_valid && smp_out_ready) begin
				recv_cnt <= recv_cnt + 32'h1;
				last_out <= smp_out_data;
			end
		end
	end
endmodule // ifnm_partner

// ==== ifnm_props.sv ====
`timescale 1ns/1ps
module ifnm_props (
	// Clock and reset
	input wire clk_sys,
	input wire rst_b,
	// Register port
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [31:0] reg_rdata,
	// Streams
	input wire smp_in_valid,
	input wire smp_in_ready,
	input wire [63:0] smp_out_data,
	input wire smp_out_valid,
	input wire smp_out_ready
);
	reg [31:0] f0_reg;
	reg [31:0] f1_reg;
	reg [15:0] p0_reg;
	reg [15:0] p1_reg;
	reg [3:0] sel_reg;
	reg [1:0] gc_reg;
	reg [31:0] echo;
	wire hold;
	assign hold = sel_reg[3];
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	// Shadow copies of what software wrote
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			f0_reg <= 32'h0;
			f1_reg <= 32'h0;
			p0_reg <= 16'h0;
			p1_reg <= 16'h0;
			sel_reg <= 4'h0;
			gc_reg <= 2'h1;
		end else if (reg_wr) begin
			case (reg_addr)
			8'h00: f0_reg <= reg_wdata;
			8'h04: f1_reg <= reg_wdata;
			8'h08: p0_reg <= reg_wdata[15:0];
			8'h0c: p1_reg <= reg_wdata[15:0];
			8'h10: sel_reg <= reg_wdata[3:0];
			8'h14: gc_reg <= reg_wdata[1:0];
			default: ;
			endcase
		end
	end
	// Readback expected for the plain registers
	always @* begin
		case (reg_addr)
		8'h00: echo = f0_reg;
		8'h04: echo = f1_reg;
		8'h08: echo = {16'h0, p0_reg};
		8'h0c: echo = {16'h0, p1_reg};
		8'h10: echo = {28'h0, sel_reg};
		8'h14: echo = {30'h0, gc_reg};
		default: echo = 32'h0;
		endcase
	end
	reg_echo_a: assert property (reg_rd && reg_addr != 8'h1c &&
		reg_addr != 8'h20 |=> reg_rdata == $past(echo))
		else $error("register readback wrong");
	rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data not zero when idle");
	acc0_step_a: assert property ((reg_rd && reg_addr == 8'h1c &&
		sel_reg == 4'h0) [*2] |=> reg_rdata == $past(reg_rdata) + $past(f0_reg))
		else $error("accumulator 0 step wrong");
	acc1_step_a: assert property ((reg_rd && reg_addr == 8'h20 &&
		sel_reg == 4'h0) [*2] |=> reg_rdata == $past(reg_rdata) + $past(f1_reg))
		else $error("accumulator 1 step wrong");
	acc_hold_a: assert property (reg_rd && hold && $past(hold) &&
		$past(hold, 2) && (reg_addr == 8'h1c || reg_addr == 8'h20)
		|=> reg_rdata == 32'h0) else $error("held accumulator not zero");
	trig_clear_a: assert property (reg_wr && reg_addr == 8'h18 &&
		sel_reg[0] ##1 reg_rd && reg_addr == 8'h1c
		|=> reg_rdata == 32'h0 || reg_rdata == $past(f0_reg))
		else $error("trigger did not clear accumulator");
	out_hold_a: assert property (smp_out_valid && !smp_out_ready
		|=> smp_out_valid && $stable(smp_out_data))
		else $error("output word dropped while stalled");
	in_busy_a: assert property (smp_in_valid && smp_in_ready
		|=> !smp_in_ready) else $error("first stage took words too fast");
endmodule // ifnm_props

// ==== interpolation_fir_nco_mixer_test.sv ====
`timescale 1ns/1ps
module interpolation_fir_nco_mixer_test;
	logic clk_sys = 0, rst_b = 0, reg_wr = 0, reg_rd = 0;
	logic sync_pin = 0, ostr_pin = 0, smp_in_valid, smp_in_ready;
	logic [7:0] reg_addr = 8'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, src_limit = 32'h0;
	logic [31:0] sent_cnt, recv_cnt, a, b;
	logic [63:0] smp_in_data, smp_out_data, last_out;
	logic smp_out_valid, smp_out_ready;
	int fail_count = 0, cmp_count = 0;
	ifnm_mixer_top DUT (.clk_sys(clk_sys), .rst_b(rst_b),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .sync_pin(sync_pin),
		.ostr_pin(ostr_pin), .smp_in_data(smp_in_data),
		.smp_in_valid(smp_in_valid), .smp_in_ready(smp_in_ready),
		.smp_out_data(smp_out_data), .smp_out_valid(smp_out_valid),
		.smp_out_ready(smp_out_ready));
	ifnm_partner u_far (.clk_sys(clk_sys), .rst_b(rst_b),
		.src_word(64'h0800_1800_1000_2000), .src_limit(src_limit),
		.smp_in_data(smp_in_data), .smp_in_valid(smp_in_valid),
		.smp_in_ready(smp_in_ready), .smp_out_data(smp_out_data),
		.smp_out_valid(smp_out_valid), .smp_out_ready(smp_out_ready),
		.sent_cnt(sent_cnt), .recv_cnt(recv_cnt), .last_out(last_out));
	// 250 MHz clock
	always #2 clk_sys = ~clk_sys;
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Mixer table is coarse, so lanes get a small tolerance
	task near(input logic [15:0] got, input logic [15:0] exp);
		logic [15:0] d;
		d = got - exp;
		if (^got !== 1'bx && (d < 16'h10 || d > 16'hfff0))
			chk(32'h0, 32'h0);
		else
			chk({16'h0, got}, {16'h0, exp});
	endtask
	task wr(input logic [7:0] ad, input logic [31:0] d);
		@(posedge clk_sys);
		reg_wr <= 1;
		reg_addr <= ad;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 0;
	endtask
	// First access of either kind, then a read right behind it
	task op2(input bit w, input logic [7:0] a0, input logic [7:0] a1,
		output logic [31:0] v0, output logic [31:0] v1);
		@(posedge clk_sys);
		reg_wr <= w;
		reg_rd <= !w;
		reg_addr <= a0;
		@(posedge clk_sys);
		reg_wr <= 0;
		reg_rd <= 1;
		reg_addr <= a1;
		@(negedge clk_sys);
		v0 = reg_rdata;
		@(posedge clk_sys);
		reg_rd <= 0;
		@(negedge clk_sys);
		v1 = reg_rdata;
	endtask
	task t_reset;
		for (int i = 0; i < 10; i++) begin
			op2(0, 8'(i * 4), 8'h24, a, b);
			chk(a, (i == 5) ? 32'h1 : 32'h0); // reset value
			chk(b, 32'h0); // unmapped
		end
	endtask
	task t_acc;
		wr(8'h00, 32'hf000_0001);
		wr(8'h04, 32'h0000_0123);
		op2(0, 8'h1c, 8'h1c, a, b);
		chk(b, a + 32'hf000_0001); // wraps
		op2(0, 8'h20, 8'h20, a, b);
		chk(b, a + 32'h0000_0123); // own word
	endtask
	task pulse(input int i);
		@(posedge clk_sys);
		{ostr_pin, sync_pin} <= i ? 2'b10 : 2'b01;
		repeat (3) @(posedge clk_sys);
		{ostr_pin, sync_pin} <= 2'b00;
		repeat (4) @(posedge clk_sys);
	endtask
	task t_sync;
		wr(8'h00, 32'h1000);
		wr(8'h10, 32'h1);
		op2(1, 8'h18, 8'h1c, a, b);
		chk(b <= 32'h1000, 1); // cleared
		pulse(0);
		op2(0, 8'h1c, 8'h1c, a, b);
		chk(a > 32'h8000, 1); // pin ignored
		for (int i = 0; i < 2; i++) begin
			wr(8'h10, 32'h2 << i);
			pulse(i);
			op2(0, 8'h1c, 8'h1c, a, b);
			chk(a <= 32'h10000, 1); // pin source
		end
		wr(8'h10, 32'h0);
		op2(1, 8'h18, 8'h1c, a, b);
		chk(b > 32'h1000, 1); // trigger ignored
		wr(8'h10, 32'h8);
		repeat (3) @(posedge clk_sys);
		op2(0, 8'h1c, 8'h20, a, b);
		chk(a | b, 32'h0); // held at zero
	endtask
	// Settle the chain on a steady input, then judge the lanes
	task t_stream(input logic [1:0] gc, input logic [15:0] p0, p1,
		input logic [63:0] e);
		wr(8'h14, {30'h0, gc});
		wr(8'h08, {16'h0, p0});
		wr(8'h0c, {16'h0, p1});
		src_limit <= src_limit + 40;
		@(posedge clk_sys);
		for (int k = 0; k < 8000 && recv_cnt != 16 * src_limit; k++)
			@(posedge clk_sys);
		repeat (64) @(posedge clk_sys);
		chk(recv_cnt, 16 * src_limit); // sixteen per word
		for (int i = 0; i < 4; i++)
			near(last_out[16 * i +: 16], e[16 * i +: 16]); // lanes
	endtask
	task give_verdict;
		$display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Watchdog well past the expected run
	initial begin
		#150000;
		fail_count++;
		give_verdict;
	end
	// Main sequence
	initial begin
		repeat (4) @(posedge clk_sys);
		rst_b <= 1;
		t_reset;
		t_acc;
		t_sync;
		t_stream(2'h1, 16'h0, 16'h0, 64'h0800_1800_1000_2000); // plain
		t_stream(2'h3, 16'h0, 16'h8000, 64'hf800_e800_1000_2000);
		t_stream(2'h2, 16'h4000, 16'hc000, 64'hf400_0400_1000_f800);
		give_verdict;
	end
endmodule // interpolation_fir_nco_mixer_test
bind ifnm_mixer_top ifnm_props u_props (.clk_sys(clk_sys), .rst_b(rst_b),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .smp_in_valid(smp_in_valid),
	.smp_in_ready(smp_in_ready), .smp_out_data(smp_out_data),
	.smp_out_valid(smp_out_valid), .smp_out_ready(smp_out_ready));
